// ---- logic/pscc_pkg.sv ----
package pscc_pkg;

   // ****************************************************************
   // Array geometry
   // ****************************************************************
   localparam int unsigned ADDR_W = 18;
   localparam int unsigned LANE_W = 8;
   localparam int unsigned LANES = 4;
   localparam int unsigned WORD_W = 36;
   localparam int unsigned EXTRA_LSB = 32;
   localparam int unsigned MEM_WORDS = 262144;

   // ****************************************************************
   // Write queue layout
   // ****************************************************************
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned ENTRY_DATA_LSB = 0;
   localparam int unsigned ENTRY_BW_LSB = WORD_W;
   localparam int unsigned ENTRY_ADDR_LSB = WORD_W + LANES;
   localparam int unsigned ENTRY_W = ADDR_W + LANES + WORD_W;
   // Room held back because the ready pin is one cycle late
   localparam int unsigned FIFO_SLACK = 3;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [1:0] CNT_RST = 2'h0;
   localparam logic [3:0] BW_RST = 4'hf;
   localparam logic STRAP_RST = 1'b1;

   // ****************************************************************
   // Cycle type held across a burst
   // ****************************************************************
   typedef enum logic [2:0] {
      PSCC_IDLE = 3'h1,
      PSCC_READ = 3'h2,
      PSCC_WRITE = 3'h4
   } pscc_state_t;

   // Burst address low bits: linear adds, interleaved xors
   function automatic logic [1:0] pscc_burst_low(input logic [1:0] seed, input logic [1:0] cnt,
                                                 input logic interleave);
      logic [1:0] r;
      r = interleave ? (seed ^ cnt) : 2'(seed + cnt);
      return r;
   endfunction

endpackage

// ---- logic/pscc_fifo_if.sv ----
`timescale 1ns/1ps
interface pscc_fifo_if #(parameter int unsigned WIDTH = 8);
   logic in_valid;
   logic [WIDTH-1:0] in_data;
   logic in_ready;
   logic in_slack;
   logic out_valid;
   logic [WIDTH-1:0] out_data;
   logic out_ready;

   modport producer(output in_valid, output in_data, input in_ready, input in_slack);
   modport consumer(input out_valid, input out_data, output out_ready);
   modport fifo(input in_valid, input in_data, output in_ready, output in_slack,
                output out_valid, output out_data, input out_ready);
endinterface

// ---- logic/pscc_fifo.sv ----
`timescale 1ns/1ps
module pscc_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32,
   parameter int unsigned SLACK = 3
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_hold,
   pscc_fifo_if.fifo q_if
);

   localparam int unsigned PW = $clog2(DEPTH);
   localparam int unsigned CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [CW-1:0] count;
   } pscc_fifo_st_t;

   pscc_fifo_st_t q;
   pscc_fifo_st_t d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   // Honest flags straight from the occupancy count
   assign q_if.in_ready = (q.count != CW'(DEPTH));
   assign q_if.in_slack = (q.count < CW'(DEPTH - SLACK));
   assign q_if.out_valid = (q.count != '0);
   assign q_if.out_data = mem[q.rd_ptr];
   assign push = q_if.in_valid && q_if.in_ready;
   assign pop = q_if.out_valid && q_if.out_ready;

   // Pointer wrap relies on a power-of-two depth
   always_comb begin
      d = q;
      if (push) begin
         d.wr_ptr = PW'(q.wr_ptr + 1'b1);
      end
      if (pop) begin
         d.rd_ptr = PW'(q.rd_ptr + 1'b1);
      end
      d.count = CW'(q.count + CW'(push) - CW'(pop));
   end

   // State register, frozen while held
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         q <= '0;
      end else if (!i_hold) begin
         q <= d;
      end
   end

   // Storage needs no reset
   always_ff @(posedge i_clock) begin
      if (!i_sys_rst && !i_hold && push) begin
         mem[q.wr_ptr] <= q_if.in_data;
      end
   end

endmodule

// ---- logic/pscc_core.sv ----
// Summary of operation
// - Cycle type from read/write select at load
// - Burst keeps type until next load
// - Low select at load starts byte write
// - All byte enables low write whole word
// - Strap low linear, high interleaved
// - One lane per byte, data registered
// - x36 keeps extra bits, x32 ignores
// - High clock enable freezes all state
// - Chip selects checked only on load
`timescale 1ns/1ps
module pscc_core #(
   parameter bit ORG_X36 = 1'b1
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_clock_enable_n,
   input wire logic i_chip_select_n,
   input wire logic i_select_depth_n,
   input wire logic i_select_depth_high,
   input wire logic i_advance_load_n,
   input wire logic i_read_write_n,
   input wire logic [pscc_pkg::ADDR_W-1:0] i_address,
   input wire logic i_burst_order_strap,
   input wire logic i_byte_write_en_a_n,
   input wire logic i_byte_write_en_b_n,
   input wire logic i_byte_write_en_c_n,
   input wire logic i_byte_write_en_d_n,
   input wire logic [pscc_pkg::LANE_W-1:0] i_byte_lane_a,
   input wire logic [pscc_pkg::LANE_W-1:0] i_byte_lane_b,
   input wire logic [pscc_pkg::LANE_W-1:0] i_byte_lane_c,
   input wire logic [pscc_pkg::LANE_W-1:0] i_byte_lane_d,
   input wire logic i_extra_bit_lane_a,
   input wire logic i_extra_bit_lane_b,
   input wire logic i_extra_bit_lane_c,
   input wire logic i_extra_bit_lane_d,
   output logic [pscc_pkg::LANE_W-1:0] o_byte_lane_a,
   output logic [pscc_pkg::LANE_W-1:0] o_byte_lane_b,
   output logic [pscc_pkg::LANE_W-1:0] o_byte_lane_c,
   output logic [pscc_pkg::LANE_W-1:0] o_byte_lane_d,
   output logic o_extra_bit_lane_a,
   output logic o_extra_bit_lane_b,
   output logic o_extra_bit_lane_c,
   output logic o_extra_bit_lane_d,
   output logic o_data_oe,
   output logic o_write_ready
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      pscc_pkg::pscc_state_t state;
      logic [pscc_pkg::ADDR_W-1:0] base;
      logic [1:0] cnt;
      logic strap;
      logic wr_pend;
      logic [pscc_pkg::ADDR_W-1:0] wr_addr;
      logic [pscc_pkg::LANES-1:0] wr_bw_n;
      logic rd_pend;
      logic [pscc_pkg::ADDR_W-1:0] rd_addr;
      logic [pscc_pkg::WORD_W-1:0] dout;
      logic oe;
      logic wready;
   } pscc_core_st_t;

   localparam pscc_core_st_t ST_RST = '{
      state: pscc_pkg::PSCC_IDLE,
      base: '0,
      cnt: pscc_pkg::CNT_RST,
      strap: pscc_pkg::STRAP_RST,
      wr_pend: 1'b0,
      wr_addr: '0,
      wr_bw_n: pscc_pkg::BW_RST,
      rd_pend: 1'b0,
      rd_addr: '0,
      dout: '0,
      oe: 1'b0,
      wready: 1'b0
   };

   pscc_core_st_t q;
   pscc_core_st_t d;
   logic [pscc_pkg::WORD_W-1:0] mem [pscc_pkg::MEM_WORDS];
   logic [pscc_pkg::WORD_W-1:0] pin_word;
   logic [pscc_pkg::WORD_W-1:0] lane_keep;
   logic [pscc_pkg::WORD_W-1:0] rd_word;
   logic [pscc_pkg::ENTRY_W-1:0] drain_entry;
   logic drain;

   pscc_fifo_if #(.WIDTH(pscc_pkg::ENTRY_W)) wq_if ();

   // ****************************************************************
   // Write queue
   // ****************************************************************
   // Decouples the data phase from the array port so reads never wait
   pscc_fifo #(
      .WIDTH(pscc_pkg::ENTRY_W),
      .DEPTH(pscc_pkg::FIFO_DEPTH),
      .SLACK(pscc_pkg::FIFO_SLACK)
   ) u_write_queue (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_hold(i_clock_enable_n),
      .q_if(wq_if.fifo)
   );

   // Bits that carry storage; the extra lanes are dead in the narrow part
   function automatic logic [pscc_pkg::WORD_W-1:0] lane_mask(input logic [pscc_pkg::LANES-1:0] bw_n);
      logic [pscc_pkg::WORD_W-1:0] m;
      m = '0;
      for (int l = 0; l < pscc_pkg::LANES; l++) begin
         m[l*pscc_pkg::LANE_W +: pscc_pkg::LANE_W] = {pscc_pkg::LANE_W{!bw_n[l]}};
         m[pscc_pkg::EXTRA_LSB + l] = !bw_n[l] && ORG_X36;
      end
      return m;
   endfunction

   // Pin data gathered into one word, byte a in the low lane
   assign pin_word = {i_extra_bit_lane_d, i_extra_bit_lane_c, i_extra_bit_lane_b, i_extra_bit_lane_a,
                      i_byte_lane_d, i_byte_lane_c, i_byte_lane_b, i_byte_lane_a};

   // Data phase: the edge after the write address captures the lanes
   assign wq_if.in_valid = q.wr_pend;
   assign wq_if.in_data = {q.wr_addr, q.wr_bw_n, pin_word};

   // Array port goes to reads first; queued writes drain in idle slots
   assign wq_if.out_ready = !q.rd_pend;
   assign drain_entry = wq_if.out_data;
   assign drain = wq_if.out_valid && wq_if.out_ready;
   assign lane_keep = lane_mask(drain_entry[pscc_pkg::ENTRY_BW_LSB +: pscc_pkg::LANES]);

   // Unwritten extra bits of the narrow part always read back as zero
   assign rd_word = mem[q.rd_addr] & (ORG_X36 ? '1 : {{(pscc_pkg::WORD_W - pscc_pkg::EXTRA_LSB){1'b0}},
                                      {pscc_pkg::EXTRA_LSB{1'b1}}});

   // ****************************************************************
   // Cycle control
   // ****************************************************************
   // Next-state for address, burst counter and both data pipelines
   always_comb begin
      logic selected;
      logic active;
      logic [1:0] next_cnt;
      logic [pscc_pkg::ADDR_W-1:0] eff_addr;
      selected = 1'b0;
      active = 1'b0;
      next_cnt = q.cnt;
      eff_addr = '0;
      d = q;
      // Strap is only followed while idle, so a stray wiggle cannot split a burst
      if (q.state == pscc_pkg::PSCC_IDLE) begin
         d.strap = i_burst_order_strap;
      end
      selected = !i_chip_select_n && !i_select_depth_n && i_select_depth_high;
      if (!i_advance_load_n) begin
         // Load: new address, cycle type, counter cleared; address low bits seed the burst
         next_cnt = pscc_pkg::CNT_RST;
         d.base = i_address;
         if (selected) begin
            d.state = i_read_write_n ? pscc_pkg::PSCC_READ : pscc_pkg::PSCC_WRITE;
            active = 1'b1;
         end else begin
            d.state = pscc_pkg::PSCC_IDLE;
         end
      end else if (q.state != pscc_pkg::PSCC_IDLE) begin
         // Advance: read/write select is ignored, type is kept
         next_cnt = 2'(q.cnt + 1'b1);
         active = 1'b1;
      end
      d.cnt = next_cnt;
      eff_addr = {d.base[pscc_pkg::ADDR_W-1:2],
                  pscc_pkg::pscc_burst_low(d.base[1:0], next_cnt, d.strap)};
      // Byte enables travel with the address of every beat
      d.wr_pend = active && (d.state == pscc_pkg::PSCC_WRITE);
      d.wr_addr = eff_addr;
      d.wr_bw_n = {i_byte_write_en_d_n, i_byte_write_en_c_n,
                   i_byte_write_en_b_n, i_byte_write_en_a_n};
      d.rd_pend = active && (d.state == pscc_pkg::PSCC_READ);
      d.rd_addr = eff_addr;
      // Read data leaves through the output register, one beat per edge
      d.oe = q.rd_pend;
      if (q.rd_pend) begin
         d.dout = rd_word;
      end
      // Registered ready keeps the pin glitch free at the cost of held slack
      d.wready = wq_if.in_slack;
   end

   // State register; the clock enable stretches the previous cycle
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         q <= ST_RST;
      end else if (!i_clock_enable_n) begin
         q <= d;
      end
   end

   // Array write with per-lane masking from the queue head
   always_ff @(posedge i_clock) begin
      if (!i_sys_rst && !i_clock_enable_n && drain) begin
         mem[drain_entry[pscc_pkg::ENTRY_ADDR_LSB +: pscc_pkg::ADDR_W]] <=
            (mem[drain_entry[pscc_pkg::ENTRY_ADDR_LSB +: pscc_pkg::ADDR_W]] & ~lane_keep) |
            (drain_entry[pscc_pkg::ENTRY_DATA_LSB +: pscc_pkg::WORD_W] & lane_keep);
      end
   end

   // ****************************************************************
   // Pin outputs
   // ****************************************************************
   // All taken from the registered state
   assign o_byte_lane_a = q.dout[0*pscc_pkg::LANE_W +: pscc_pkg::LANE_W];
   assign o_byte_lane_b = q.dout[1*pscc_pkg::LANE_W +: pscc_pkg::LANE_W];
   assign o_byte_lane_c = q.dout[2*pscc_pkg::LANE_W +: pscc_pkg::LANE_W];
   assign o_byte_lane_d = q.dout[3*pscc_pkg::LANE_W +: pscc_pkg::LANE_W];
   assign o_extra_bit_lane_a = q.dout[pscc_pkg::EXTRA_LSB];
   assign o_extra_bit_lane_b = q.dout[pscc_pkg::EXTRA_LSB + 1];
   assign o_extra_bit_lane_c = q.dout[pscc_pkg::EXTRA_LSB + 2];
   assign o_extra_bit_lane_d = q.dout[pscc_pkg::EXTRA_LSB + 3];
   assign o_data_oe = q.oe;
   assign o_write_ready = q.wready;

endmodule

// ---- tb/pscc_core_asserts.sv ----
`timescale 1ns/1ps
module pscc_core_chk (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_clock_enable_n,
   input wire logic i_chip_select_n,
   input wire logic i_select_depth_n,
   input wire logic i_select_depth_high,
   input wire logic i_advance_load_n,
   input wire logic i_read_write_n,
   input wire logic [pscc_pkg::LANE_W-1:0] o_byte_lane_a,
   input wire logic o_data_oe,
   input wire logic o_write_ready
);
   // ****************************************************************
   // Pin cycle checks
   // ****************************************************************
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   logic sel;
   // All three selects active together
   assign sel = !i_chip_select_n && !i_select_depth_n && i_select_depth_high;
   sequence s_ld(rw);
      !i_clock_enable_n && !i_advance_load_n && sel && i_read_write_n == rw;
   endsequence
   sequence s_des;
      !i_clock_enable_n && !i_advance_load_n && !sel;
   endsequence
   sequence s_adv;
      !i_clock_enable_n && i_advance_load_n;
   endsequence
   // One enabled edge: the beat loaded before it reaches the output register
   sequence s_run;
      !i_clock_enable_n;
   endsequence
   property p_rd;
      s_ld(1) ##1 s_run |=> o_data_oe;
   endproperty
   property p_wr;
      s_ld(0) ##1 s_run |=> !o_data_oe;
   endproperty
   property p_keep;
      s_ld(1) ##1 s_adv ##1 s_run |=> o_data_oe;
   endproperty
   property p_wr_adv;
      s_ld(0) ##1 s_adv ##1 s_run |=> !o_data_oe;
   endproperty
   property p_desel;
      s_des ##1 s_run |=> !o_data_oe;
   endproperty
   property p_adv_idle;
      s_des ##1 s_adv ##1 s_run |=> !o_data_oe;
   endproperty
   // Output enable is one beat wide when a write load follows
   property p_single;
      s_ld(1) ##1 s_ld(0) ##1 s_run |-> o_data_oe ##1 !o_data_oe;
   endproperty
   property p_freeze;
      i_clock_enable_n |=> $stable(o_data_oe) && $stable(o_byte_lane_a) && $stable(o_write_ready);
   endproperty
   a_rd: assert property (p_rd) else $error("read beat missing");
   a_wr: assert property (p_wr) else $error("write gave a read beat");
   a_keep: assert property (p_keep) else $error("burst lost read type");
   a_wr_adv: assert property (p_wr_adv) else $error("write burst turned to read");
   a_desel: assert property (p_desel) else $error("deselected load answered");
   a_adv_idle: assert property (p_adv_idle) else $error("advance while idle answered");
   a_single: assert property (p_single) else $error("read beat width wrong");
   a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
endmodule

// ---- tb/pscc_host.sv ----
`timescale 1ns/1ps
module pscc_host (
   input wire logic i_clock,
   output logic o_ce_n,
   output logic [2:0] o_sel,
   output logic o_ld_n,
   output logic o_rw_n,
   output logic [pscc_pkg::ADDR_W-1:0] o_addr,
   output logic o_strap,
   output logic [3:0] o_bw_n,
   output logic [pscc_pkg::WORD_W-1:0] o_wd
);
   logic [pscc_pkg::WORD_W-1:0] nxt;
   // Deselected idle pins from time zero
   initial begin
      o_ce_n = 1'h0;
      o_sel = 3'h6;
      o_ld_n = 1'h1;
      o_rw_n = 1'h1;
      o_addr = 18'h0_0000;
      o_strap = 1'h0;
      o_bw_n = 4'hf;
      o_wd = 36'h0_0000_0000;
      nxt = 36'h5_a5a5_a5a5;
   end
   // One beat per edge; lanes carry the previous write beat's data
   task automatic beat(input logic ld_n, rw_n, input logic [2:0] s, input logic [17:0] a,
                       input logic [3:0] bw_n, input logic [35:0] d);
      @(posedge i_clock);
      o_ce_n <= 1'h0;
      o_ld_n <= ld_n;
      o_rw_n <= rw_n;
      o_sel <= s;
      o_addr <= a;
      o_bw_n <= bw_n;
      o_wd <= nxt;
      // Lanes not written show changing junk, never stale data
      nxt <= (rw_n && !ld_n) ? ~nxt : d;
   endtask
   // Clock enable high stretches the cycle
   task automatic hold(input int n);
      repeat (n) begin
         @(posedge i_clock);
         o_ce_n <= 1'h1;
      end
   endtask
   // Strap moves only between idle beats, never inside a burst
   task automatic mode(input logic m);
      beat(1'h0, 1'h1, 3'h6, 18'h0_0000, 4'hf, 36'h0_0000_0000);
      @(posedge i_clock);
      o_strap <= m;
      beat(1'h0, 1'h1, 3'h6, 18'h0_0000, 4'hf, 36'h0_0000_0000);
   endtask
endmodule

// ---- tb/tb_pscc_core.sv ----
`timescale 1ns/1ps
module tb_pscc_core;
   logic i_clock = 1'h0;
   logic i_sys_rst = 1'h1;
   logic ce_n, ld_n, rw_n, strap, oe, wrdy, rdm;
   logic [2:0] sel;
   logic [17:0] addr;
   logic [3:0] bw_n, ex;
   logic [35:0] wd, word;
   logic [3:0][7:0] q;
   logic [35:0] nw, rexp;
   logic [35:0] mem [int];
   logic [35:0] exq [$];
   int failures = 0;
   int cmp_count = 0;
   assign word = {ex, q[3], q[2], q[1], q[0]};
   // Free running clock
   always #2.5 i_clock = ~i_clock;
   pscc_host i_pscc_host (.i_clock(i_clock), .o_ce_n(ce_n), .o_sel(sel), .o_ld_n(ld_n), .o_rw_n(rw_n),
      .o_addr(addr), .o_strap(strap), .o_bw_n(bw_n), .o_wd(wd));
   pscc_core i_pscc_core (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clock_enable_n(ce_n),
      .i_chip_select_n(sel[2]), .i_select_depth_n(sel[1]), .i_select_depth_high(sel[0]),
      .i_advance_load_n(ld_n), .i_read_write_n(rw_n), .i_address(addr), .i_burst_order_strap(strap),
      .i_byte_write_en_a_n(bw_n[0]), .i_byte_write_en_b_n(bw_n[1]), .i_byte_write_en_c_n(bw_n[2]),
      .i_byte_write_en_d_n(bw_n[3]), .i_byte_lane_a(wd[7:0]), .i_byte_lane_b(wd[15:8]),
      .i_byte_lane_c(wd[23:16]), .i_byte_lane_d(wd[31:24]), .i_extra_bit_lane_a(wd[32]),
      .i_extra_bit_lane_b(wd[33]), .i_extra_bit_lane_c(wd[34]), .i_extra_bit_lane_d(wd[35]),
      .o_byte_lane_a(q[0]), .o_byte_lane_b(q[1]), .o_byte_lane_c(q[2]), .o_byte_lane_d(q[3]),
      .o_extra_bit_lane_a(ex[0]), .o_extra_bit_lane_b(ex[1]), .o_extra_bit_lane_c(ex[2]),
      .o_extra_bit_lane_d(ex[3]), .o_data_oe(oe), .o_write_ready(wrdy));
   // Narrow part on the same pins; its extra lanes must always read back as zero
   pscc_core #(.ORG_X36(1'b0)) i_pscc_core_x32 (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_clock_enable_n(ce_n), .i_chip_select_n(sel[2]), .i_select_depth_n(sel[1]),
      .i_select_depth_high(sel[0]), .i_advance_load_n(ld_n), .i_read_write_n(rw_n), .i_address(addr),
      .i_burst_order_strap(strap), .i_byte_write_en_a_n(bw_n[0]), .i_byte_write_en_b_n(bw_n[1]),
      .i_byte_write_en_c_n(bw_n[2]), .i_byte_write_en_d_n(bw_n[3]), .i_byte_lane_a(wd[7:0]),
      .i_byte_lane_b(wd[15:8]), .i_byte_lane_c(wd[23:16]), .i_byte_lane_d(wd[31:24]),
      .i_extra_bit_lane_a(wd[32]), .i_extra_bit_lane_b(wd[33]), .i_extra_bit_lane_c(wd[34]),
      .i_extra_bit_lane_d(wd[35]), .o_byte_lane_a(nw[7:0]), .o_byte_lane_b(nw[15:8]),
      .o_byte_lane_c(nw[23:16]), .o_byte_lane_d(nw[31:24]), .o_extra_bit_lane_a(nw[32]),
      .o_extra_bit_lane_b(nw[33]), .o_extra_bit_lane_c(nw[34]), .o_extra_bit_lane_d(nw[35]),
      .o_data_oe(), .o_write_ready());
   task automatic check(input string what, input logic [35:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test;
      if (failures == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Each enabled edge with the output enable up carries exactly one beat
   always @(posedge i_clock) begin
      if (oe === 1'h1 && ce_n === 1'h0) begin
         if (exq.size() == 0)
            check("spare beat", 36'h0_0000_0001, 36'h0_0000_0000);
         else begin
            rexp = exq.pop_front();
            check("read data", word, rexp);
            check("narrow read data", nw, rexp & 36'h0_ffff_ffff);
         end
      end
   end
   // ****************************************************************
   // Pin helpers with a reference memory
   // ****************************************************************
   task automatic put(input logic [17:0] a, input logic [3:0] b, input logic [35:0] d);
      logic [35:0] m;
      m = mem.exists(a) ? mem[a] : 36'hx;
      for (int i = 0; i < 4; i++) begin
         if (!b[i]) begin
            m[8*i+:8] = d[8*i+:8];
            m[32+i] = d[32+i];
         end
      end
      mem[a] = m;
   endtask
   task automatic wr(input logic [17:0] a, input logic [3:0] b, input logic [35:0] d);
      i_pscc_host.beat(1'h0, 1'h0, 3'h1, a, b, d);
      put(a, b, d);
      rdm = 1'h0;
   endtask
   task automatic rd(input logic [17:0] a);
      i_pscc_host.beat(1'h0, 1'h1, 3'h1, a, 4'hf, 36'h0_0000_0000);
      exq.push_back(mem[a]);
      rdm = 1'h1;
   endtask
   // Advance drives the opposite select type and no chip select to show both ignored
   task automatic adv(input logic [17:0] a, input logic [35:0] d);
      i_pscc_host.beat(1'h1, ~rdm, 3'h6, 18'h0_0000, 4'h0, d);
      if (rdm)
         exq.push_back(mem[a]);
      else
         put(a, 4'h0, d);
   endtask
   task automatic des;
      i_pscc_host.beat(1'h0, 1'h1, 3'h6, 18'h0_0000, 4'hf, 36'h0_0000_0000);
   endtask
   task automatic fin;
      repeat (4) des;
      check("beats left", 36'(exq.size()), 36'h0_0000_0000);
      check("write ready", 36'(wrdy), 36'h0_0000_0001);
   endtask
   function automatic logic [17:0] nth(input logic [1:0] s, input int c, input int m);
      return 18'h0_0020 | 18'(m ? s ^ c[1:0] : 2'(s + c[1:0]));
   endfunction
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_basic;
      for (int i = 0; i < 4; i++) wr(18'(i), 4'h0, 36'(i + 1) * 36'h2_1111_1111);
      repeat (3) des;
      for (int i = 0; i < 4; i++) rd(18'(i));
      rd(18'h0_0000);
      wr(18'h0_0010, 4'h0, 36'h0_c0ff_ee01);
      rd(18'h0_0001);
      fin;
   endtask
   task automatic t_mask;
      wr(18'h0_0008, 4'h0, 36'h0_0000_0000);
      for (int i = 0; i < 4; i++) wr(18'h0_0008, ~4'(4'h1 << i), 36'hf_a5c3_5a3c >> i);
      repeat (3) des;
      rd(18'h0_0008);
      fin;
   endtask
   task automatic t_burst;
      for (int m = 0; m < 2; m++) begin
         i_pscc_host.mode(m[0]);
         wr(18'h0_0023, 4'h0, 36'h7_0000_00a0);
         for (int c = 1; c < 4; c++) adv(nth(2'h3, c, m), 36'(c) * 36'h1_0101_0101);
         repeat (3) des;
         for (int a = 32; a < 36; a++) rd(18'(a));
         rd(18'h0_0021);
         for (int c = 1; c < 4; c++) adv(nth(2'h1, c, m), 36'h0_0000_0000);
         fin;
      end
   endtask
   task automatic t_freeze;
      rd(18'h0_0020);
      i_pscc_host.hold(3);
      rd(18'h0_0022);
      i_pscc_host.hold(2);
      fin;
   endtask
   task automatic t_desel;
      for (int i = 0; i < 3; i++) begin
         i_pscc_host.beat(1'h0, 1'h1, 3'h1 ^ 3'(1 << i), 18'h0_0020, 4'hf, 36'h0_0000_0000);
         i_pscc_host.beat(1'h1, 1'h1, 3'h1, 18'h0_0000, 4'hf, 36'h0_0000_0000);
      end
      fin;
   endtask
   // Reset, then the scenarios in turn
   initial begin
      rdm = 1'h0;
      repeat (5) @(posedge i_clock);
      i_sys_rst <= 1'h0;
      t_basic;
      t_mask;
      t_burst;
      t_freeze;
      t_desel;
      end_of_test;
   end
   // Watchdog well beyond the hundred or so cycles the scenarios need
   initial begin
      #20000;
      failures++;
      end_of_test;
   end
endmodule
bind pscc_core pscc_core_chk i_pscc_core_chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
   .i_clock_enable_n(i_clock_enable_n), .i_chip_select_n(i_chip_select_n),
   .i_select_depth_n(i_select_depth_n), .i_select_depth_high(i_select_depth_high),
   .i_advance_load_n(i_advance_load_n), .i_read_write_n(i_read_write_n),
   .o_byte_lane_a(o_byte_lane_a), .o_data_oe(o_data_oe), .o_write_ready(o_write_ready));
